/* analog_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module analog_core_model
  import cmp_pkg::*;
(
  input  wire logic [3:0]  posInputSel,
  input  wire logic [3:0]  negInputSel,
  input  wire logic [1:0]  responseModeSel,
  input  wire logic [15:0] pinHigh,
  output logic             compareIn
);
  logic target;

  // pin selection
  // even pins feed the plus side, odd pins the minus side; port 1 is bits 15..8
  assign target = pinHigh[{posInputSel[2:0], 1'b0}] & ~pinHigh[{negInputSel[2:0], 1'b1}];

  // response delay
  // slower modes answer later, and rising takes twice the falling time
  // one process owns the output so it has a single driver
  initial begin
    compareIn = 1'b0;
    forever begin
      @(target);
      compareIn <= #((responseModeSel + 1) * (target ? 40 : 20)) target;
    end
  end
endmodule

`default_nettype wire

/* cmp_pkg.sv */
package cmp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CTRL_INDEX      = 8'h9B;
  localparam logic [7:0]  MODE_INDEX      = 8'h9D;
  localparam logic [7:0]  INSEL_INDEX     = 8'h9F;
  localparam logic [7:0]  INT_STAT_INDEX  = 8'hA0;
  localparam logic [7:0]  INT_MASK_INDEX  = 8'hA1;

  // control register fields
  localparam int          CTRL_EN_BIT     = 7;
  localparam int          CTRL_OUT_BIT    = 6;
  localparam int          CTRL_RISE_BIT   = 5;
  localparam int          CTRL_FALL_BIT   = 4;
  localparam int          CTRL_HYP_LSB    = 2;
  localparam int          CTRL_HYN_LSB    = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;

  // mode register fields
  localparam int          MODE_RISE_IE    = 5;
  localparam int          MODE_FALL_IE    = 4;
  localparam int          MODE_MD_LSB     = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h02;

  // input select fields
  localparam int          INSEL_NEG_LSB   = 4;
  localparam int          INSEL_POS_LSB   = 0;
  localparam logic [7:0]  INSEL_RESET     = 8'h77;

  // interrupt status and mask layout
  localparam int          INT_RISE_BIT    = 1;
  localparam int          INT_FALL_BIT    = 0;
  localparam logic [1:0]  INT_RESET       = 2'h0;

  // bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    SEL_CTRL  = 3'h0,
    SEL_MODE  = 3'h1,
    SEL_INSEL = 3'h2,
    SEL_STAT  = 3'h3,
    SEL_MASK  = 3'h4,
    SEL_NONE  = 3'h7
  } reg_sel_e;

endpackage

/* compare_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module compare_sync (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic stable;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  // first stage feeds only the second; change counts once stages two and three agree
  always_comb begin
    state_next        = state_reg;
    state_next.ff1    = asyncIn;
    state_next.ff2    = state_reg.ff1;
    state_next.ff3    = state_reg.ff2;
    if (state_reg.ff2 == state_reg.ff3) begin
      state_next.stable = state_reg.ff3;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stable;

endmodule

`default_nettype wire

/* voltage_comparator_control.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - falling edge of comparator output sets fall flag, control bit 4
// - rising edge of comparator output sets rise flag, control bit 5
// - edge flags stay set until software writes zero
// - control bit 6 is read-only present comparator result
// - control bit 7 enables comparator, resets to zero
// - disabled comparator drives its pin outputs low
// - enabled comparator with low output requests oscillator wake
// - one clock-registered output and one raw unclocked output
// - control bits 3..2 pick positive hysteresis, forwarded to analog core
// - control bits 1..0 pick negative hysteresis, forwarded to analog core
// - input select upper nibble picks negative input pin
// - input select lower nibble picks positive input pin
// - mode bits 5 and 4 enable rise and fall interrupt requests
// - edge interrupt needs local enable and matching global rise or fall interrupt enable
// - mode bits 1..0 select response time, reset value 0x02
// - mode bit 7 reserved, unused mode bits read zero, ignore writes
module voltage_comparator_control
  import cmp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              compareIn,
  input  wire logic              globalRiseIrqEnable,
  input  wire logic              globalFallIrqEnable,
  output logic                   compareEnable,
  output logic [1:0]             posHystSel,
  output logic [1:0]             negHystSel,
  output logic [3:0]             posInputSel,
  output logic [3:0]             negInputSel,
  output logic [1:0]             responseModeSel,
  output logic                   syncedCompareOut,
  output logic                   rawCompareOut,
  output logic                   wakeRequest,
  output logic                   riseIrqReq,
  output logic                   fallIrqReq,
  output logic                   irq
);

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_e;

  typedef struct packed {
    wr_state_e   wrState;
    logic        awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic        wHeld;
    logic [7:0]  wByte;
    logic        wLane;
    logic        awReady;
    logic        wReady;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [7:0]  rByte;
    logic [1:0]  rResp;
    logic        enable;
    logic        riseFlag;
    logic        fallFlag;
    logic [1:0]  posHyst;
    logic [1:0]  negHyst;
    logic        riseIe;
    logic        fallIe;
    logic [1:0]  respMode;
    logic [7:0]  inSel;
    logic        prevOut;
    logic [1:0]  intStat;
    logic [1:0]  intMask;
    logic        syncedOut;
    logic        riseReq;
    logic        fallReq;
    logic        irqOut;
  } ctl_s;

  ctl_s state_reg;
  ctl_s state_next;

  logic compareResult;
  logic riseEdge;
  logic fallEdge;
  logic ctrlWrite;

  function automatic reg_sel_e decodeAddr(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        (ADDR_W-2)'(CTRL_INDEX):     sel = SEL_CTRL;
        (ADDR_W-2)'(MODE_INDEX):     sel = SEL_MODE;
        (ADDR_W-2)'(INSEL_INDEX):    sel = SEL_INSEL;
        (ADDR_W-2)'(INT_STAT_INDEX): sel = SEL_STAT;
        (ADDR_W-2)'(INT_MASK_INDEX): sel = SEL_MASK;
        default:                     sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  compare_sync u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .asyncIn (compareIn),
    .syncOut (compareResult)
  );

  assign riseEdge = state_reg.enable & compareResult & ~state_reg.prevOut;
  assign fallEdge = state_reg.enable & ~compareResult & state_reg.prevOut;

  assign ctrlWrite = (state_reg.wrState == WR_COLLECT) & state_reg.awHeld & state_reg.wHeld
                     & state_reg.wLane & (decodeAddr(state_reg.awAddr) == SEL_CTRL);

  always_comb begin
    state_next         = state_reg;
    state_next.prevOut = compareResult;

    // write address and data may arrive in either order
    if (awvalid && state_reg.awReady) begin
      state_next.awHeld = 1'b1;
      state_next.awAddr = awaddr;
    end
    if (wvalid && state_reg.wReady) begin
      state_next.wHeld = 1'b1;
      state_next.wByte = wdata[7:0];
      state_next.wLane = wstrb[0];
    end

    case (state_reg.wrState)
      WR_COLLECT: begin
        if (state_reg.awHeld && state_reg.wHeld) begin
          state_next.awHeld  = 1'b0;
          state_next.wHeld   = 1'b0;
          state_next.bValid  = 1'b1;
          state_next.bResp   = RESP_OKAY;
          state_next.wrState = WR_RESP;
          if (state_reg.wLane) begin
            case (decodeAddr(state_reg.awAddr))
              SEL_CTRL: begin
                state_next.enable   = state_reg.wByte[CTRL_EN_BIT];
                state_next.riseFlag = state_reg.wByte[CTRL_RISE_BIT];
                state_next.fallFlag = state_reg.wByte[CTRL_FALL_BIT];
                state_next.posHyst  = state_reg.wByte[CTRL_HYP_LSB +: 2];
                state_next.negHyst  = state_reg.wByte[CTRL_HYN_LSB +: 2];
              end
              SEL_MODE: begin
                state_next.riseIe   = state_reg.wByte[MODE_RISE_IE];
                state_next.fallIe   = state_reg.wByte[MODE_FALL_IE];
                state_next.respMode = state_reg.wByte[MODE_MD_LSB +: 2];
              end
              SEL_INSEL: state_next.inSel = state_reg.wByte;
              SEL_STAT:  state_next.intStat = state_reg.intStat & ~state_reg.wByte[1:0];
              SEL_MASK:  state_next.intMask = state_reg.wByte[1:0];
              default:   state_next.bResp = RESP_SLVERR;
            endcase
          end else if (decodeAddr(state_reg.awAddr) == SEL_NONE) begin
            state_next.bResp = RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (bready) begin
          state_next.bValid  = 1'b0;
          state_next.wrState = WR_COLLECT;
        end
      end
      default: begin
        state_next.wrState = WR_COLLECT;
        state_next.bValid  = 1'b0;
      end
    endcase

    // hardware set wins over a software clear in the same cycle
    // rise and fall flag set
    if (riseEdge) begin
      state_next.riseFlag = 1'b1;
      state_next.intStat[INT_RISE_BIT] = 1'b1;
    end
    if (fallEdge) begin
      state_next.fallFlag = 1'b1;
      state_next.intStat[INT_FALL_BIT] = 1'b1;
    end

    // read path; one read in flight at a time
    if (state_reg.rValid && rready) begin
      state_next.rValid = 1'b0;
    end
    if (arvalid && state_reg.arReady) begin
      state_next.rValid = 1'b1;
      state_next.rResp  = RESP_OKAY;
      case (decodeAddr(araddr))
        SEL_CTRL:  state_next.rByte = {state_reg.enable, compareResult, state_reg.riseFlag,
                                       state_reg.fallFlag, state_reg.posHyst, state_reg.negHyst};
        SEL_MODE:  state_next.rByte = {2'h0, state_reg.riseIe, state_reg.fallIe, 2'h0, state_reg.respMode};
        SEL_INSEL: state_next.rByte = state_reg.inSel;
        SEL_STAT:  state_next.rByte = {6'h00, state_reg.intStat};
        SEL_MASK:  state_next.rByte = {6'h00, state_reg.intMask};
        default: begin
          state_next.rByte = 8'h00;
          state_next.rResp = RESP_SLVERR;
        end
      endcase
    end

    state_next.awReady = (state_next.wrState == WR_COLLECT) & ~state_next.awHeld;
    state_next.wReady  = (state_next.wrState == WR_COLLECT) & ~state_next.wHeld;
    state_next.arReady = ~state_next.rValid;

    state_next.syncedOut = state_reg.enable & compareResult;
    state_next.riseReq = state_reg.riseFlag & state_reg.riseIe;
    state_next.fallReq = state_reg.fallFlag & state_reg.fallIe;
    // local and global enables both needed
    state_next.irqOut = |(state_reg.intStat & state_reg.intMask
                          & {state_reg.riseIe & globalRiseIrqEnable,
                             state_reg.fallIe & globalFallIrqEnable});
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.wrState  <= WR_COLLECT;
      state_reg.awReady  <= 1'b1;
      state_reg.wReady   <= 1'b1;
      state_reg.arReady  <= 1'b1;
      state_reg.enable   <= CTRL_RESET[CTRL_EN_BIT];
      state_reg.posHyst  <= CTRL_RESET[CTRL_HYP_LSB +: 2];
      state_reg.negHyst  <= CTRL_RESET[CTRL_HYN_LSB +: 2];
      state_reg.riseIe   <= MODE_RESET[MODE_RISE_IE];
      state_reg.fallIe   <= MODE_RESET[MODE_FALL_IE];
      state_reg.respMode <= MODE_RESET[MODE_MD_LSB +: 2];
      state_reg.inSel    <= INSEL_RESET;
      state_reg.intStat  <= INT_RESET;
      state_reg.intMask  <= INT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready          = state_reg.awReady;
  assign wready           = state_reg.wReady;
  assign bvalid           = state_reg.bValid;
  assign bresp            = state_reg.bResp;
  assign arready          = state_reg.arReady;
  assign rvalid           = state_reg.rValid;
  assign rresp            = state_reg.rResp;
  assign rdata            = {24'h000000, state_reg.rByte};
  assign compareEnable    = state_reg.enable;
  assign posHystSel       = state_reg.posHyst;
  assign negHystSel       = state_reg.negHyst;
  assign posInputSel      = state_reg.inSel[INSEL_POS_LSB +: 4];
  assign negInputSel      = state_reg.inSel[INSEL_NEG_LSB +: 4];
  assign responseModeSel  = state_reg.respMode;
  assign syncedCompareOut = state_reg.syncedOut;
  assign riseIrqReq       = state_reg.riseReq;
  assign fallIrqReq       = state_reg.fallReq;
  assign irq              = state_reg.irqOut;

  // raw path must work with the clock stopped, so it bypasses all flops but the enable
  // raw unclocked output
  assign rawCompareOut = state_reg.enable & compareIn;
  assign wakeRequest   = state_reg.enable & ~compareIn;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_ctrl_read;
    arvalid && arready && (decodeAddr(araddr) == SEL_CTRL);
  endsequence

  sequence s_mode_read;
    arvalid && arready && (decodeAddr(araddr) == SEL_MODE);
  endsequence

  a_rise_flag_set: assert property (riseEdge |=> state_reg.riseFlag)
    else $error("rise flag not set after rising edge");

  a_fall_flag_set: assert property (fallEdge |=> state_reg.fallFlag)
    else $error("fall flag not set after falling edge");

  a_flag_sticky: assert property ((state_reg.riseFlag && !ctrlWrite) |=> state_reg.riseFlag)
    else $error("rise flag dropped without software write");

  a_fall_sticky: assert property ((state_reg.fallFlag && !ctrlWrite) |=> state_reg.fallFlag)
    else $error("fall flag dropped without software write");

  a_result_readback: assert property (s_ctrl_read |=> rvalid && (rdata[6] == $past(compareResult)))
    else $error("control read does not show comparator result");

  a_enable_write: assert property (ctrlWrite |=> compareEnable == $past(state_reg.wByte[7]))
    else $error("enable bit not taken from write");

  a_pin_low: assert property (!compareEnable |=> !syncedCompareOut)
    else $error("pin output not low while disabled");

  a_mode_reserved: assert property (s_mode_read |=> (rdata[7:6] == 2'h0) && (rdata[3:2] == 2'h0))
    else $error("reserved mode bits read nonzero");

  a_rise_request: assert property (##1 riseIrqReq == $past(state_reg.riseFlag && state_reg.riseIe))
    else $error("rise request does not follow flag and enable");

  a_irq_gate: assert property (irq |-> $past(globalRiseIrqEnable || globalFallIrqEnable))
    else $error("interrupt without global enable");

  a_write_answer: assert property (ctrlWrite |=> bvalid ##0 (bresp == RESP_OKAY))
    else $error("write not answered next cycle");

endmodule

`default_nettype wire

/* voltage_comparator_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module voltage_comparator_control_tb
  import cmp_pkg::*;
;
  logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, globalRise, globalFall;
  logic        awready, wready, bvalid, arready, rvalid, compareIn, compareEnable;
  logic        syncedCompareOut, rawCompareOut, wakeRequest, riseIrqReq, fallIrqReq, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, posInputSel, negInputSel;
  logic [1:0]  bresp, rresp, rsp, posHystSel, negHystSel, responseModeSel;
  logic [15:0] pinHigh;
  logic [7:0]  rd, v;
  logic [2:0]  pSel, nSel;
  int          err_count, cmp_count, seed, i;

  voltage_comparator_control u_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .compareIn(compareIn),
    .globalRiseIrqEnable(globalRise), .globalFallIrqEnable(globalFall), .compareEnable(compareEnable),
    .posHystSel(posHystSel), .negHystSel(negHystSel), .posInputSel(posInputSel),
    .negInputSel(negInputSel), .responseModeSel(responseModeSel), .syncedCompareOut(syncedCompareOut),
    .rawCompareOut(rawCompareOut), .wakeRequest(wakeRequest), .riseIrqReq(riseIrqReq),
    .fallIrqReq(fallIrqReq), .irq(irq));

  analog_core_model u_core (.posInputSel(posInputSel), .negInputSel(negInputSel),
    .responseModeSel(responseModeSel), .pinHigh(pinHigh), .compareIn(compareIn));

  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  function automatic logic [7:0] ctl(input logic en, input logic o, input logic r, input logic f);
    return {en, o, r, f, 4'h0};
  endfunction

  task automatic wrr(input logic [7:0] idx, input logic [7:0] d);
    bit a, w, b;
    int n;
    a = 0; w = 0; b = 0; n = 0;
    @(posedge mclk);
    awaddr <= adr(idx); wdata <= {24'h0, d}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b && n < 50) begin
      @(negedge mclk);
      a = awvalid && awready; w = wvalid && wready; b = bvalid; rsp = bresp;
      @(posedge mclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
    end
    if (!b) err_count++;
    // registered outputs are looked at only once they have settled
    @(negedge mclk);
  endtask

  task automatic rdr(input logic [7:0] idx);
    bit a, r;
    int n;
    a = 0; r = 0; n = 0;
    @(posedge mclk);
    araddr <= adr(idx); arvalid <= 1'b1; rready <= 1'b1;
    while (!r && n < 50) begin
      @(negedge mclk);
      a = arvalid && arready; r = rvalid; rd = rdata[7:0]; rsp = rresp;
      @(posedge mclk);
      if (a) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
      n++;
    end
    if (!r) err_count++;
    @(negedge mclk);
  endtask

  // moves the analog pins, then lets the synchroniser settle
  task automatic setcmp(input logic lvl);
    @(posedge mclk);
    pinHigh <= lvl ? (16'h1 << {pSel, 1'b0}) : 16'h0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #(20000 * 25);
    err_count++;
    end_sim;
  end

  initial begin
    seed = 6; err_count = 0; cmp_count = 0; rst = 1'b1; pinHigh = 16'h0; pSel = 3'h7;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; globalRise = 1; globalFall = 1;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rdr(CTRL_INDEX);
    `CHK(rd, CTRL_RESET)
    `CHK(rsp, RESP_OKAY)
    rdr(MODE_INDEX);
    `CHK(rd, MODE_RESET)
    rdr(INSEL_INDEX);
    `CHK(rd, INSEL_RESET)
    // unmapped places answer with an error and keep nothing
    rdr(8'h10);
    `CHK(rsp, RESP_SLVERR)
    wrr(8'h10, 8'hFF);
    `CHK(rsp, RESP_SLVERR)
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      v[7] = 1'b0;
      v[1:0] = i[1:0];
      wrr(MODE_INDEX, v);
      `CHK(rsp, RESP_OKAY)
      rdr(MODE_INDEX);
      `CHK(rd, v & 8'h33)
      `CHK(responseModeSel, i[1:0])
      wrr(CTRL_INDEX, {4'h0, i[1:0], ~i[1:0]});
      `CHK(posHystSel, i[1:0])
      `CHK(negHystSel, ~i[1:0])
    end
    for (i = 0; i < 8; i++) begin
      pSel = 3'($random(seed));
      nSel = 3'($random(seed));
      wrr(INSEL_INDEX, {1'b0, nSel, 1'b0, pSel});
      `CHK(posInputSel, {1'b0, pSel})
      `CHK(negInputSel, {1'b0, nSel})
    end
    // disabled: pins stay low and edges go unseen
    setcmp(1'b1);
    `CHK(rawCompareOut, 1'b0)
    `CHK(syncedCompareOut, 1'b0)
    `CHK(wakeRequest, 1'b0)
    rdr(CTRL_INDEX);
    `CHK(rd[5:4], 2'h0)
    `CHK(rd[6], 1'b1)
    setcmp(1'b0);
    wrr(CTRL_INDEX, 8'h80);
    wrr(MODE_INDEX, 8'h30);
    repeat (20) @(posedge mclk);
    wrr(CTRL_INDEX, 8'h80);
    `CHK(compareEnable, 1'b1)
    `CHK(wakeRequest, 1'b1)
    `CHK(responseModeSel, 2'h0)
    wrr(INT_MASK_INDEX, 8'h03);
    wrr(INT_STAT_INDEX, 8'h03);
    setcmp(1'b1);
    `CHK(rawCompareOut, 1'b1)
    `CHK(syncedCompareOut, 1'b1)
    `CHK(wakeRequest, 1'b0)
    `CHK(riseIrqReq, 1'b1)
    `CHK(fallIrqReq, 1'b0)
    `CHK(irq, 1'b1)
    rdr(CTRL_INDEX);
    `CHK(rd, ctl(1, 1, 1, 0))
    setcmp(1'b0);
    rdr(CTRL_INDEX);
    `CHK(rd, ctl(1, 0, 1, 1))
    `CHK(fallIrqReq, 1'b1)
    @(posedge mclk);
    globalRise <= 1'b0;
    globalFall <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK(irq, 1'b0)
    @(posedge mclk);
    globalRise <= 1'b1;
    wrr(INT_MASK_INDEX, 8'h01);
    `CHK(irq, 1'b0)
    wrr(INT_MASK_INDEX, 8'h03);
    `CHK(irq, 1'b1)
    wrr(INT_STAT_INDEX, 8'h03);
    rdr(INT_STAT_INDEX);
    `CHK(rd, 8'h00)
    `CHK(irq, 1'b0)
    // writing zero clears the sticky flags
    wrr(CTRL_INDEX, 8'h80);
    rdr(CTRL_INDEX);
    `CHK(rd, ctl(1, 0, 0, 0))
    `CHK(riseIrqReq, 1'b0)
    // a second reset in mid-run brings every register back
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK(compareEnable, 1'b0)
    `CHK(responseModeSel, MODE_RESET[1:0])
    `CHK(irq, 1'b0)
    rdr(INSEL_INDEX);
    `CHK(rd, INSEL_RESET)
    end_sim;
  end
endmodule

`default_nettype wire
